//--- aia_regs.sv
// Register bank of the eight-channel analog input module
`timescale 1ns/1ps
`default_nettype none
module aia_regs #(
  parameter logic [15:0] MODULE_TYPE = 16'h5A3C // Arbitrary value
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         smp_valid_i,
  input  wire logic [2:0]   smp_chan_i,
  input  wire logic [15:0]  smp_data_i,
  input  wire logic         boot_start_i,
  input  wire logic [15:0]  restart_cause_i,
  input  wire logic         pair_link_fail_i,
  input  wire logic         reg_rd_i,
  input  wire logic         reg_wr_i,
  input  wire logic [1:0]   reg_space_i,
  input  wire logic [15:0]  reg_addr_i,
  input  wire logic [15:0]  reg_wdata_i,
  output logic      [15:0]  reg_rdata_o,
  output logic              reg_ack_o,
  output logic              reg_err_o,
  output logic      [7:0]   node_identifier_o,
  output logic      [127:0] ai_range_code_o,
  output logic      [7:0]   hi_alarm_o,
  output logic      [7:0]   lo_alarm_o
);
  // ==========================================================================
  // Decode helpers
  function automatic logic in8(input logic [15:0] a, input logic [15:0] b);
    in8 = (a >= b) && (a < b + 16'h0008);
  endfunction : in8

  function automatic logic [2:0] idx(input logic [15:0] a,
                                     input logic [15:0] b);
    logic [15:0] d;
    d   = a - b;
    idx = d[2:0];
  endfunction : idx

  function automatic logic range_ok(input logic [15:0] v);
    range_ok = ((v >= aia_pkg::RANGE_MIN) && (v <= aia_pkg::RANGE_MAX))
               || (v == aia_pkg::RANGE_ALT);
  endfunction : range_ok

  // ==========================================================================
  // State
  logic [15:0] node_id;
  logic [15:0] hi_thr   [8];
  logic [15:0] lo_thr   [8];
  logic [15:0] range_cd [8];
  logic [7:0]  hi_mode;
  logic [7:0]  lo_mode;
  logic [15:0] cause;
  logic [15:0] boot;
  logic [15:0] rdata;
  logic        ack;
  logic        err;
  logic [15:0] next_node_id;
  logic [15:0] next_hi_thr   [8];
  logic [15:0] next_lo_thr   [8];
  logic [15:0] next_range_cd [8];
  logic [7:0]  next_hi_mode;
  logic [7:0]  next_lo_mode;
  logic [15:0] next_cause;
  logic [15:0] next_boot;
  logic [15:0] next_rdata;
  logic        next_ack;
  logic        next_err;

  // Per-channel control pulses and gathered readback
  logic [7:0]  hi_clr;
  logic [7:0]  lo_clr;
  logic [7:0]  peak_clr;
  logic [7:0]  trough_clr;
  logic [15:0] samp_a   [8];
  logic [15:0] peak_a   [8];
  logic [15:0] trough_a [8];
  logic [7:0]  hi_f;
  logic [7:0]  lo_f;
  logic        factory;
  logic        wbit;

  assign wbit = reg_wdata_i[0];

  // ==========================================================================
  // Channel engines
  aia_ch_if ch_if [8] ();

  genvar g;
  generate
    for (g = 0; g < aia_pkg::CHANNELS; g++)
    begin : g_ch
      assign ch_if[g].smp_we     = smp_valid_i && (smp_chan_i == 3'(g));
      assign ch_if[g].smp_data   = smp_data_i;
      assign ch_if[g].hi_thr     = hi_thr[g];
      assign ch_if[g].lo_thr     = lo_thr[g];
      assign ch_if[g].hi_latch   = hi_mode[g];
      assign ch_if[g].lo_latch   = lo_mode[g];
      assign ch_if[g].hi_clr     = hi_clr[g];
      assign ch_if[g].lo_clr     = lo_clr[g];
      assign ch_if[g].peak_clr   = peak_clr[g];
      assign ch_if[g].trough_clr = trough_clr[g];
      assign samp_a[g]           = ch_if[g].sample;
      assign peak_a[g]           = ch_if[g].peak;
      assign trough_a[g]         = ch_if[g].trough;
      assign hi_f[g]             = ch_if[g].hi_flag;
      assign lo_f[g]             = ch_if[g].lo_flag;
      assign ai_range_code_o[16*g +: 16] = range_cd[g];

      aia_channel u_ch (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .ch        (ch_if[g].chn)
      );
    end
  endgenerate

  // ==========================================================================
  // Coil write pulses; only a written 1 acts
  always_comb
  begin
    hi_clr     = 8'h00;
    lo_clr     = 8'h00;
    peak_clr   = 8'h00;
    trough_clr = 8'h00;
    factory    = 1'b0;
    if (reg_wr_i && (reg_space_i == aia_pkg::AIA_SP_COIL) && wbit)
    begin
      if (in8(reg_addr_i, aia_pkg::OFF_HI_CLR))
        hi_clr[idx(reg_addr_i, aia_pkg::OFF_HI_CLR)] = 1'b1;
      else if (in8(reg_addr_i, aia_pkg::OFF_LO_CLR))
        lo_clr[idx(reg_addr_i, aia_pkg::OFF_LO_CLR)] = 1'b1;
      else if (in8(reg_addr_i, aia_pkg::OFF_CLR_PEAK_CH))
        peak_clr[idx(reg_addr_i, aia_pkg::OFF_CLR_PEAK_CH)] = 1'b1;
      else if (in8(reg_addr_i, aia_pkg::OFF_CLR_TROUGH_CH))
        trough_clr[idx(reg_addr_i, aia_pkg::OFF_CLR_TROUGH_CH)] = 1'b1;
      else if (reg_addr_i == aia_pkg::OFF_CLR_PEAK_ALL)
        peak_clr = 8'hFF;
      else if (reg_addr_i == aia_pkg::OFF_CLR_TROUGH_ALL)
        trough_clr = 8'hFF;
      else if (reg_addr_i == aia_pkg::OFF_FACTORY)
        factory = 1'b1;
    end
  end

  // ==========================================================================
  // Register writes, restart bookkeeping and read answers
  always_comb
  begin
    next_node_id  = node_id;
    next_hi_thr   = hi_thr;
    next_lo_thr   = lo_thr;
    next_range_cd = range_cd;
    next_hi_mode  = hi_mode;
    next_lo_mode  = lo_mode;
    next_cause    = cause;
    next_boot     = boot;
    next_rdata    = rdata;
    next_ack      = reg_rd_i || reg_wr_i;
    next_err      = 1'b0;
    if (reg_wr_i)
    begin
      if (reg_space_i == aia_pkg::AIA_SP_HOLD)
      begin
        if (reg_addr_i == aia_pkg::OFF_NODE)
        begin
          if (reg_wdata_i <= aia_pkg::NODE_MAX)
            next_node_id = reg_wdata_i;
          else
            next_err = 1'b1;
        end
        else if (in8(reg_addr_i, aia_pkg::OFF_HI_THR))
          next_hi_thr[idx(reg_addr_i, aia_pkg::OFF_HI_THR)] = reg_wdata_i;
        else if (in8(reg_addr_i, aia_pkg::OFF_LO_THR))
          next_lo_thr[idx(reg_addr_i, aia_pkg::OFF_LO_THR)] = reg_wdata_i;
        else if (in8(reg_addr_i, aia_pkg::OFF_RANGE) && range_ok(reg_wdata_i))
          next_range_cd[idx(reg_addr_i, aia_pkg::OFF_RANGE)] = reg_wdata_i;
        else
          next_err = 1'b1; // Bad code, read-only word or hole
      end
      else if (reg_space_i == aia_pkg::AIA_SP_COIL)
      begin
        if (in8(reg_addr_i, aia_pkg::OFF_HI_MODE))
          next_hi_mode[idx(reg_addr_i, aia_pkg::OFF_HI_MODE)] = wbit;
        else if (in8(reg_addr_i, aia_pkg::OFF_LO_MODE))
          next_lo_mode[idx(reg_addr_i, aia_pkg::OFF_LO_MODE)] = wbit;
        else if (!(in8(reg_addr_i, aia_pkg::OFF_HI_CLR)
                || in8(reg_addr_i, aia_pkg::OFF_LO_CLR)
                || in8(reg_addr_i, aia_pkg::OFF_CLR_PEAK_CH)
                || in8(reg_addr_i, aia_pkg::OFF_CLR_TROUGH_CH)
                || reg_addr_i == aia_pkg::OFF_CLR_PEAK_ALL
                || reg_addr_i == aia_pkg::OFF_CLR_TROUGH_ALL
                || reg_addr_i == aia_pkg::OFF_FACTORY))
          next_err = 1'b1;
      end
      else
        next_err = 1'b1; // Flags and input words are read-only
    end
    else if (reg_rd_i)
    begin
      next_rdata = 16'h0000;
      if (reg_space_i == aia_pkg::AIA_SP_DISC)
      begin
        if (in8(reg_addr_i, aia_pkg::OFF_HI_FLAG))
          next_rdata[0] = hi_f[idx(reg_addr_i, aia_pkg::OFF_HI_FLAG)];
        else if (in8(reg_addr_i, aia_pkg::OFF_LO_FLAG))
          next_rdata[0] = lo_f[idx(reg_addr_i, aia_pkg::OFF_LO_FLAG)];
        else
          next_err = 1'b1;
      end
      else if (reg_space_i == aia_pkg::AIA_SP_INPUT)
      begin
        if (in8(reg_addr_i, aia_pkg::OFF_SAMPLE))
          next_rdata = samp_a[idx(reg_addr_i, aia_pkg::OFF_SAMPLE)];
        else if (in8(reg_addr_i, aia_pkg::OFF_PEAK))
          next_rdata = peak_a[idx(reg_addr_i, aia_pkg::OFF_PEAK)];
        else if (in8(reg_addr_i, aia_pkg::OFF_TROUGH))
          next_rdata = trough_a[idx(reg_addr_i, aia_pkg::OFF_TROUGH)];
        else if (reg_addr_i == aia_pkg::OFF_CH_COUNT)
          next_rdata = aia_pkg::CH_COUNT;
        else if (reg_addr_i == aia_pkg::OFF_LINK)
          next_rdata = pair_link_fail_i ? aia_pkg::LINK_FAIL
                                        : aia_pkg::LINK_OK;
        else
          next_err = 1'b1;
      end
      else if (reg_space_i == aia_pkg::AIA_SP_HOLD)
      begin
        if (reg_addr_i == aia_pkg::OFF_NODE)
          next_rdata = node_id;
        else if (in8(reg_addr_i, aia_pkg::OFF_HI_THR))
          next_rdata = hi_thr[idx(reg_addr_i, aia_pkg::OFF_HI_THR)];
        else if (in8(reg_addr_i, aia_pkg::OFF_LO_THR))
          next_rdata = lo_thr[idx(reg_addr_i, aia_pkg::OFF_LO_THR)];
        else if (in8(reg_addr_i, aia_pkg::OFF_RANGE))
          next_rdata = range_cd[idx(reg_addr_i, aia_pkg::OFF_RANGE)];
        else if (reg_addr_i == aia_pkg::OFF_CAUSE)
          next_rdata = cause;
        else if (reg_addr_i == aia_pkg::OFF_BOOT)
          next_rdata = boot;
        else if (reg_addr_i == aia_pkg::OFF_TYPE)
          next_rdata = MODULE_TYPE;
        else
          next_err = 1'b1;
      end
      else
      begin
        if (in8(reg_addr_i, aia_pkg::OFF_HI_MODE))
          next_rdata[0] = hi_mode[idx(reg_addr_i, aia_pkg::OFF_HI_MODE)];
        else if (in8(reg_addr_i, aia_pkg::OFF_LO_MODE))
          next_rdata[0] = lo_mode[idx(reg_addr_i, aia_pkg::OFF_LO_MODE)];
        // Clear controls are write-only and read as zero
      end
    end
    // Factory restore returns settings and clears the boot count
    if (factory)
    begin
      next_node_id = aia_pkg::RST_NODE;
      next_hi_mode = 8'h00;
      next_lo_mode = 8'h00;
      next_boot    = aia_pkg::BOOT_ZERO;
      for (int i = 0; i < aia_pkg::CHANNELS; i++)
      begin
        next_hi_thr[i]   = aia_pkg::RST_HI_THR;
        next_lo_thr[i]   = aia_pkg::RST_LO_THR;
        next_range_cd[i] = aia_pkg::RST_RANGE;
      end
    end
    // A start counts after any restore in the same cycle
    if (boot_start_i)
    begin
      if (next_boot < aia_pkg::BOOT_MAX)
        next_boot = next_boot + aia_pkg::BOOT_STEP;
      if ((restart_cause_i >= aia_pkg::CAUSE_POWER)
          && (restart_cause_i <= aia_pkg::CAUSE_SOFT))
        next_cause = restart_cause_i;
    end
  end

  // Registers; settings return to factory values under reset
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      node_id <= aia_pkg::RST_NODE;
      for (int i = 0; i < aia_pkg::CHANNELS; i++)
      begin
        hi_thr[i]   <= aia_pkg::RST_HI_THR;
        lo_thr[i]   <= aia_pkg::RST_LO_THR;
        range_cd[i] <= aia_pkg::RST_RANGE;
      end
      hi_mode <= 8'h00;
      lo_mode <= 8'h00;
      cause   <= aia_pkg::CAUSE_NONE;
      boot    <= aia_pkg::BOOT_ZERO;
      rdata   <= 16'h0000;
      ack     <= 1'b0;
      err     <= 1'b0;
    end
    else
    begin
      node_id  <= next_node_id;
      hi_thr   <= next_hi_thr;
      lo_thr   <= next_lo_thr;
      range_cd <= next_range_cd;
      hi_mode  <= next_hi_mode;
      lo_mode  <= next_lo_mode;
      cause    <= next_cause;
      boot     <= next_boot;
      rdata    <= next_rdata;
      ack      <= next_ack;
      err      <= next_err;
    end
  end

  // Outputs
  assign reg_rdata_o       = rdata;
  assign reg_ack_o         = ack;
  assign reg_err_o         = err;
  assign node_identifier_o = node_id[7:0];
  assign hi_alarm_o        = hi_f;
  assign lo_alarm_o        = lo_f;
endmodule : aia_regs
`default_nettype wire

//--- aia_pkg.sv
// Constants and types for the analog input alarm register bank
`default_nettype none
package aia_pkg;
  // ==========================================================================
  // Sizes
  localparam int CHANNELS = 8;
  localparam int DW       = 16;
  localparam int AW       = 16;

  // ==========================================================================
  // Modbus table spaces
  typedef enum logic [1:0] {
    AIA_SP_COIL  = 2'b00,
    AIA_SP_DISC  = 2'b01,
    AIA_SP_INPUT = 2'b10,
    AIA_SP_HOLD  = 2'b11
  } aia_space_t;

  // ==========================================================================
  // Offsets within each space
  localparam logic [15:0] OFF_HI_FLAG        = 16'h00E0;
  localparam logic [15:0] OFF_LO_FLAG        = 16'h0100;
  localparam logic [15:0] OFF_SAMPLE         = 16'h0000;
  localparam logic [15:0] OFF_PEAK           = 16'h00EC;
  localparam logic [15:0] OFF_TROUGH         = 16'h010C;
  localparam logic [15:0] OFF_CH_COUNT       = 16'h0140;
  localparam logic [15:0] OFF_LINK           = 16'h0168;
  localparam logic [15:0] OFF_NODE           = 16'h010F;
  localparam logic [15:0] OFF_HI_THR         = 16'h0128;
  localparam logic [15:0] OFF_LO_THR         = 16'h0148;
  localparam logic [15:0] OFF_RANGE          = 16'h01AB;
  localparam logic [15:0] OFF_CAUSE          = 16'h022B;
  localparam logic [15:0] OFF_BOOT           = 16'h022C;
  localparam logic [15:0] OFF_TYPE           = 16'h022F;
  localparam logic [15:0] OFF_CLR_PEAK_CH    = 16'h00A2;
  localparam logic [15:0] OFF_CLR_TROUGH_CH  = 16'h00C2;
  localparam logic [15:0] OFF_FACTORY        = 16'h00E2;
  localparam logic [15:0] OFF_CLR_PEAK_ALL   = 16'h027A;
  localparam logic [15:0] OFF_CLR_TROUGH_ALL = 16'h027B;
  localparam logic [15:0] OFF_HI_MODE        = 16'h02BC;
  localparam logic [15:0] OFF_LO_MODE        = 16'h02DC;
  localparam logic [15:0] OFF_HI_CLR         = 16'h02FC;
  localparam logic [15:0] OFF_LO_CLR         = 16'h031C;

  // ==========================================================================
  // Reset values, limits and codes
  localparam logic [15:0] RST_NODE    = 16'h0001;
  localparam logic [15:0] NODE_MAX    = 16'h00FF;
  localparam logic [15:0] RST_HI_THR  = 16'h7FFF;
  localparam logic [15:0] RST_LO_THR  = 16'h8000;
  localparam logic [15:0] RST_RANGE   = 16'h0008;
  localparam logic [15:0] RANGE_MIN   = 16'h0007;
  localparam logic [15:0] RANGE_MAX   = 16'h000D;
  localparam logic [15:0] RANGE_ALT   = 16'h001A;
  localparam logic [15:0] RST_PEAK    = 16'h8000;
  localparam logic [15:0] RST_TROUGH  = 16'h7FFF;
  localparam logic [15:0] RST_SAMPLE  = 16'h0000;
  localparam logic [15:0] CH_COUNT    = 16'h0008;
  localparam logic [15:0] LINK_OK     = 16'h0000;
  localparam logic [15:0] LINK_FAIL   = 16'hFFFF;
  localparam logic [15:0] CAUSE_NONE  = 16'h0000;
  localparam logic [15:0] CAUSE_POWER = 16'h0001;
  localparam logic [15:0] CAUSE_SOFT  = 16'h0003;
  localparam logic [15:0] BOOT_MAX    = 16'h7FFF;
  localparam logic [15:0] BOOT_ZERO   = 16'h0000;
  localparam logic [15:0] BOOT_STEP   = 16'h0001;
endpackage : aia_pkg
`default_nettype wire

//--- aia_ch_if.sv
// Interface between the register bank and one channel engine
`timescale 1ns/1ps
`default_nettype none
interface aia_ch_if;
  logic        smp_we;
  logic [15:0] smp_data;
  logic [15:0] hi_thr;
  logic [15:0] lo_thr;
  logic        hi_latch;
  logic        lo_latch;
  logic        hi_clr;
  logic        lo_clr;
  logic        peak_clr;
  logic        trough_clr;
  logic [15:0] sample;
  logic [15:0] peak;
  logic [15:0] trough;
  logic        hi_flag;
  logic        lo_flag;

  // Register bank side
  modport ctl (output smp_we, smp_data, hi_thr, lo_thr, hi_latch, lo_latch,
               hi_clr, lo_clr, peak_clr, trough_clr,
               input  sample, peak, trough, hi_flag, lo_flag);
  // Channel engine side
  modport chn (input  smp_we, smp_data, hi_thr, lo_thr, hi_latch, lo_latch,
               hi_clr, lo_clr, peak_clr, trough_clr,
               output sample, peak, trough, hi_flag, lo_flag);
endinterface : aia_ch_if
`default_nettype wire

//--- aia_channel.sv
// One channel: live sample, history and alarm comparison
`timescale 1ns/1ps
`default_nettype none
module aia_channel (
  input  wire logic sys_clk_i,
  input  wire logic rst_b_i,
  aia_ch_if.chn     ch
);
  // ==========================================================================
  // Channel state
  logic [15:0] sample;
  logic [15:0] peak;
  logic [15:0] trough;
  logic        hi_flag;
  logic        lo_flag;
  logic [15:0] next_sample;
  logic [15:0] next_peak;
  logic [15:0] next_trough;
  logic        next_hi_flag;
  logic        next_lo_flag;
  logic        hi_cmp;
  logic        lo_cmp;

  // History restart values, shared by reset and the clear path
  localparam logic [15:0] RST_PEAK_L   = aia_pkg::RST_PEAK;
  localparam logic [15:0] RST_TROUGH_L = aia_pkg::RST_TROUGH;

  // Signed comparisons against the thresholds
  assign hi_cmp = $signed(ch.smp_data) > $signed(ch.hi_thr);
  assign lo_cmp = $signed(ch.smp_data) < $signed(ch.lo_thr);

  // Next values; a clear and a new sample in one cycle keep the sample
  always_comb
  begin
    next_sample  = sample;
    next_peak    = ch.peak_clr ? RST_PEAK_L : peak;
    next_trough  = ch.trough_clr ? RST_TROUGH_L : trough;
    next_hi_flag = ch.hi_clr ? 1'b0 : hi_flag;
    next_lo_flag = ch.lo_clr ? 1'b0 : lo_flag;
    if (ch.smp_we)
    begin
      next_sample = ch.smp_data;
      if ($signed(ch.smp_data) > $signed(next_peak))
        next_peak = ch.smp_data;
      if ($signed(ch.smp_data) < $signed(next_trough))
        next_trough = ch.smp_data;
      // Latching only sets, so a set beats a same-cycle clear
      if (ch.hi_latch)
        next_hi_flag = next_hi_flag | hi_cmp;
      else
        next_hi_flag = hi_cmp;
      if (ch.lo_latch)
        next_lo_flag = next_lo_flag | lo_cmp;
      else
        next_lo_flag = lo_cmp;
    end
  end

  // Registers
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      sample  <= aia_pkg::RST_SAMPLE;
      peak    <= aia_pkg::RST_PEAK;
      trough  <= aia_pkg::RST_TROUGH;
      hi_flag <= 1'b0;
      lo_flag <= 1'b0;
    end
    else
    begin
      sample  <= next_sample;
      peak    <= next_peak;
      trough  <= next_trough;
      hi_flag <= next_hi_flag;
      lo_flag <= next_lo_flag;
    end
  end

  // Outputs straight from flip-flops
  assign ch.sample  = sample;
  assign ch.peak    = peak;
  assign ch.trough  = trough;
  assign ch.hi_flag = hi_flag;
  assign ch.lo_flag = lo_flag;
endmodule : aia_channel
`default_nettype wire

//--- aia_regs_monitor.sv
// Concurrent property checker for the register bank's top-level ports
`timescale 1ns/1ps
`default_nettype none
module aia_regs_monitor (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         pair_link_fail_i,
  input  wire logic         reg_rd_i,
  input  wire logic         reg_wr_i,
  input  wire logic [1:0]   reg_space_i,
  input  wire logic [15:0]  reg_addr_i,
  input  wire logic [15:0]  reg_wdata_i,
  input  wire logic [15:0]  reg_rdata_o,
  input  wire logic         reg_ack_o,
  input  wire logic         reg_err_o,
  input  wire logic [7:0]   node_identifier_o,
  input  wire logic [127:0] ai_range_code_o
);
  // ==========================================================================
  // Request decode; write wins over read in the same cycle
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic rq = reg_rd_i || reg_wr_i;
  wire logic hw = reg_wr_i && reg_space_i == 2'h3;
  wire logic rr = reg_rd_i && !reg_wr_i && reg_space_i == 2'h2;
  wire logic nd = hw && reg_addr_i == 16'h010F;
  wire logic rg = hw && reg_addr_i >= 16'h01AB && reg_addr_i <= 16'h01B2;
  wire logic ok = (reg_wdata_i >= 16'h0007 && reg_wdata_i <= 16'h000D)
                  || reg_wdata_i == 16'h001A;

  // ==========================================================================
  // Answers, refusals and fixed words
  chk_ack_follows: assert property (rq |=> reg_ack_o)
    else $error("ack missing after request");
  chk_ack_cause: assert property (reg_ack_o |-> $past(rq))
    else $error("ack without request");
  chk_node_limit: assert property
    (nd && reg_wdata_i > 16'h00FF |=> reg_err_o && $stable(node_identifier_o))
    else $error("node above limit taken");
  chk_node_take: assert property
    (nd && reg_wdata_i <= 16'h00FF |=>
     {8'h00, node_identifier_o} == $past(reg_wdata_i))
    else $error("node write lost");
  chk_count_word: assert property
    (rr && reg_addr_i == 16'h0140 |=> reg_rdata_o == 16'h0008 && !reg_err_o)
    else $error("channel count wrong");
  chk_link_word: assert property (rr && reg_addr_i == 16'h0168 |=>
    reg_rdata_o == ($past(pair_link_fail_i) ? 16'hFFFF : 16'h0000))
    else $error("link word wrong");
  chk_type_ro: assert property
    (hw && reg_addr_i == 16'h022F |=> reg_err_o)
    else $error("type word write not refused");
  chk_range_bad: assert property
    (rg && !ok |=> reg_err_o && $stable(ai_range_code_o))
    else $error("illegal range code taken");
  cover property (rg && ok);
  cover property (nd);
  cover property (rr && reg_addr_i == 16'h0168 && pair_link_fail_i);
endmodule : aia_regs_monitor
bind aia_regs aia_regs_monitor mon (.sys_clk_i, .rst_b_i, .pair_link_fail_i,
  .reg_rd_i, .reg_wr_i, .reg_space_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
  .reg_ack_o, .reg_err_o, .node_identifier_o, .ai_range_code_o);
`default_nettype wire

//--- aia_host_model.sv
// Remote host model that issues register reads and writes
`timescale 1ns/1ps
`default_nettype none
module aia_host_model (
  input  wire logic        sys_clk_i,
  input  wire logic [15:0] reg_rdata_i,
  input  wire logic        reg_ack_i,
  input  wire logic        reg_err_i,
  output var  logic        reg_rd_o,
  output var  logic        reg_wr_o,
  output var  logic [1:0]  reg_space_o,
  output var  logic [15:0] reg_addr_o,
  output var  logic [15:0] reg_wdata_o
);
  // ==========================================================================
  // One-cycle request pulse, then a short bounded wait for the answer
  initial {reg_rd_o, reg_wr_o, reg_space_o, reg_addr_o, reg_wdata_o} = '0;
  task automatic xfer(input logic w, input logic [1:0] s, input logic [15:0] a,
                      input logic [15:0] d, output logic [15:0] r,
                      output logic e);
    int n;
    @(posedge sys_clk_i) #1;
    {reg_wr_o, reg_rd_o} = {w, !w};
    {reg_space_o, reg_addr_o, reg_wdata_o} = {s, a, d};
    @(posedge sys_clk_i) #1;
    {reg_wr_o, reg_rd_o} = 2'h0;
    {reg_addr_o, reg_wdata_o} = ~{a, d}; // Idle lines must not look valid
    for (n = 0; n < 4 && reg_ack_i !== 1'b1; n++) @(posedge sys_clk_i) #1;
    {r, e} = {reg_rdata_i, reg_err_i};
  endtask : xfer
endmodule : aia_host_model
`default_nettype wire

//--- aia_regs_tb_top.sv
// Self-checking bench for the analog input alarm register bank
`timescale 1ns/1ps
`default_nettype none
module aia_regs_tb_top;
  logic         sys_clk_i = 1'h0, rst_b_i = 1'h0, smp_valid_i = 1'h0;
  logic         boot_start_i = 1'h0, pair_link_fail_i = 1'h0;
  logic         reg_rd_i, reg_wr_i, reg_ack_o, reg_err_o;
  logic [1:0]   reg_space_i;
  logic [2:0]   smp_chan_i = 3'h0;
  logic [7:0]   node_identifier_o, hi_alarm_o, lo_alarm_o;
  logic [15:0]  smp_data_i = 16'h0000, restart_cause_i = 16'h0000;
  logic [15:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [127:0] ai_range_code_o;
  int           fails = 0, tests_run = 0, cyc = 0;
  // Rows: write, space, offset, data, expected read data or error bit
  localparam logic [50:0] ROWS [13] = '{
    {1'h0, 2'h2, 16'h0140, 16'h0000, 16'h0008},
    {1'h0, 2'h3, 16'h010F, 16'h0000, 16'h0001},
    {1'h0, 2'h3, 16'h0128, 16'h0000, 16'h7FFF},
    {1'h0, 2'h3, 16'h0148, 16'h0000, 16'h8000},
    {1'h0, 2'h3, 16'h01AB, 16'h0000, 16'h0008},
    {1'h0, 2'h3, 16'h022F, 16'h0000, 16'h3C5A},
    {1'h1, 2'h3, 16'h022F, 16'h0000, 16'h0001},
    {1'h1, 2'h3, 16'h010F, 16'h0100, 16'h0001},
    {1'h1, 2'h3, 16'h010F, 16'h00FF, 16'h0000},
    {1'h1, 2'h3, 16'h01AB, 16'h001A, 16'h0000},
    {1'h0, 2'h3, 16'h01AB, 16'h0000, 16'h001A},
    {1'h1, 2'h3, 16'h01B2, 16'h000E, 16'h0001},
    {1'h1, 2'h1, 16'h00E0, 16'h0001, 16'h0001}};

  // ==========================================================================
  // Clock, design, host model; type word value is arbitrary
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  aia_regs #(.MODULE_TYPE(16'h3C5A)) dut (.*);
  aia_host_model host (.sys_clk_i, .reg_rdata_i(reg_rdata_o),
    .reg_ack_i(reg_ack_o), .reg_err_i(reg_err_o), .reg_rd_o(reg_rd_i),
    .reg_wr_o(reg_wr_i), .reg_space_o(reg_space_i),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));

  task automatic cmp(input logic [15:0] g, input logic [15:0] x);
    tests_run++;
    if (g !== x)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask : cmp
  task automatic acc(input logic w, input logic [1:0] s, input logic [15:0] a,
                     input logic [15:0] d, input logic [15:0] x);
    logic [15:0] r;
    logic        e;
    host.xfer(w, s, a, d, r, e);
    cmp(w ? {15'h0000, e} : r, x);
  endtask : acc
  // Sample pulse; data lines scrambled afterwards so stale values show
  task automatic smp(input logic [15:0] d);
    @(posedge sys_clk_i) #1;
    {smp_valid_i, smp_chan_i, smp_data_i} = {1'h1, 3'h0, d};
    @(posedge sys_clk_i) #1;
    {smp_valid_i, smp_data_i} = {1'h0, ~d};
  endtask : smp
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  // ==========================================================================
  // Hang guard, well above the expected run length
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (2) @(posedge sys_clk_i);
    #1 rst_b_i = 1'h1;
    foreach (ROWS[i])
      acc(ROWS[i][50], ROWS[i][49:48], ROWS[i][47:32], ROWS[i][31:16],
          ROWS[i][15:0]);
    cmp(ai_range_code_o[15:0], 16'h001A);
    $display("Register table test done");
    acc(1'h1, 2'h3, 16'h0128, 16'h0100, 16'h0000);
    acc(1'h1, 2'h3, 16'h0148, 16'h0000, 16'h0000);
    smp(16'h0200);
    cmp({14'h0000, hi_alarm_o[0], lo_alarm_o[0]}, 16'h0002);
    smp(16'hFF00);
    cmp({14'h0000, hi_alarm_o[0], lo_alarm_o[0]}, 16'h0001);
    acc(1'h0, 2'h2, 16'h00EC, 16'h0000, 16'h0200);
    acc(1'h0, 2'h2, 16'h010C, 16'h0000, 16'hFF00);
    acc(1'h1, 2'h0, 16'h02BC, 16'h0001, 16'h0000);
    acc(1'h0, 2'h0, 16'h02BC, 16'h0000, 16'h0001);
    smp(16'h0200);
    smp(16'h0000);
    cmp({15'h0000, hi_alarm_o[0]}, 16'h0001);
    acc(1'h1, 2'h0, 16'h02FC, 16'h0001, 16'h0000);
    cmp({15'h0000, hi_alarm_o[0]}, 16'h0000);
    acc(1'h1, 2'h0, 16'h027A, 16'h0001, 16'h0000);
    acc(1'h0, 2'h2, 16'h00EC, 16'h0000, 16'h8000);
    acc(1'h1, 2'h0, 16'h02DC, 16'h0001, 16'h0000);
    smp(16'hFF00);
    smp(16'h0000);
    cmp({15'h0000, lo_alarm_o[0]}, 16'h0001);
    acc(1'h1, 2'h0, 16'h031C, 16'h0001, 16'h0000);
    cmp({15'h0000, lo_alarm_o[0]}, 16'h0000);
    acc(1'h1, 2'h0, 16'h027B, 16'h0001, 16'h0000);
    acc(1'h0, 2'h2, 16'h010C, 16'h0000, 16'h7FFF);
    $display("Alarm and history test done");
    @(posedge sys_clk_i) #1;
    {boot_start_i, restart_cause_i, pair_link_fail_i} = {1'h1, 16'h0003, 1'h1};
    @(posedge sys_clk_i) #1;
    boot_start_i = 1'h0;
    acc(1'h0, 2'h3, 16'h022B, 16'h0000, 16'h0003);
    acc(1'h0, 2'h3, 16'h022C, 16'h0000, 16'h0001);
    acc(1'h0, 2'h2, 16'h0168, 16'h0000, 16'hFFFF);
    acc(1'h1, 2'h0, 16'h00E2, 16'h0001, 16'h0000);
    acc(1'h0, 2'h3, 16'h022C, 16'h0000, 16'h0000);
    cmp({8'h00, node_identifier_o}, 16'h0001);
    cmp(ai_range_code_o[15:0], 16'h0008);
    $display("Boot and factory test done");
    // Mid-run reset drops the cause and the peak history
    @(posedge sys_clk_i) #1;
    rst_b_i = 1'h0;
    @(posedge sys_clk_i) #1;
    rst_b_i = 1'h1;
    acc(1'h0, 2'h3, 16'h022B, 16'h0000, 16'h0000);
    acc(1'h0, 2'h2, 16'h00EC, 16'h0000, 16'h8000);
    $display("Mid-run reset test done");
    end_of_test();
  end
endmodule : aia_regs_tb_top
`default_nettype wire
